// [rtl/lcdh_defines.svh]
`ifndef LCDH_DEFINES_SVH
`define LCDH_DEFINES_SVH

// Bits per serial byte, shifted in most significant bit first
`define LCDH_BYTE_BITS 8
// Width of the serial bit counter
`define LCDH_BITCNT_W 3
// Last bit index of a serial byte
`define LCDH_LAST_BIT 3'h7
// Width of the burst length field carried by the length command
`define LCDH_LEN_W 8
// Width of the burst byte counter, enough for 256
`define LCDH_BURST_W 9
// Column address width
`define LCDH_COL_W 7
// Reset values
`define LCDH_COL_RST 7'h00
`define LCDH_BYTE_RST 8'h00
`define LCDH_BURST_RST 9'h000
// Strap bit positions in the packed strap word
`define LCDH_STRAP_A_BIT 1
`define LCDH_STRAP_B_BIT 0

`endif

// [rtl/lcdh_pkg.sv]
package lcdh_pkg;

	// Port type chosen by the two straps {a, b}
	typedef enum logic [1:0] {
		LCDH_SER3 = 2'b00,
		LCDH_SER4 = 2'b01,
		LCDH_P80 = 2'b10,
		LCDH_P68 = 2'b11
	} lcdh_mode_e;

	// Parallel access tracking
	typedef enum logic [1:0] {
		LCDH_IDLE = 2'b00,
		LCDH_WRITE = 2'b01,
		LCDH_READ = 2'b10
	} lcdh_acc_e;

endpackage

// [rtl/lcdh_serial_rx.sv]
`include "lcdh_defines.svh"

module lcdh_serial_rx (
	input wire logic i_sclk,
	// System reset, used here only while the link clock stands still
	input wire logic i_reset,
	input wire logic i_cs_n,
	input wire logic i_serial_in_line,
	input wire logic i_data_cmd_select,
	output logic [`LCDH_BYTE_BITS-1:0] o_byte,
	output logic o_byte_rs,
	output logic o_byte_tgl
);

	// Bit position within the current byte
	logic [`LCDH_BITCNT_W-1:0] bit_cnt_ff;
	// Shift register, older bits toward the top
	logic [`LCDH_BYTE_BITS-2:0] shift_ff;
	// Completed byte held for the system domain
	logic [`LCDH_BYTE_BITS-1:0] byte_ff;
	logic rs_ff;
	// Flips once per completed byte
	logic tgl_ff;

	// Bit counter; the clock stops outside frames, so chip select itself
	// clears a partial byte rather than waiting for an edge that never comes
	always_ff @(posedge i_sclk or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt_ff <= '0;
		end else begin
			bit_cnt_ff <= bit_cnt_ff + 1'b1;
		end
	end

	// Shift in on each rising clock edge, first bit is the top bit
	always_ff @(posedge i_sclk) begin
		shift_ff <= {shift_ff[`LCDH_BYTE_BITS-3:0], i_serial_in_line};
	end

	// Eighth edge completes the byte and hands it over
	always_ff @(posedge i_sclk) begin
		if (!i_cs_n && bit_cnt_ff == `LCDH_LAST_BIT) begin
			byte_ff <= {shift_ff, i_serial_in_line};
			rs_ff <= i_data_cmd_select;
		end
	end

	// Toggle event; must start known or the system side never sees a byte.
	// Reset comes while select is high and the link clock is stopped, so
	// its release cannot meet a clock edge
	always_ff @(posedge i_sclk or posedge i_reset) begin
		if (i_reset) begin
			tgl_ff <= 1'b0;
		end else if (!i_cs_n && bit_cnt_ff == `LCDH_LAST_BIT) begin
			tgl_ff <= ~tgl_ff;
		end
	end

	assign o_byte = byte_ff;
	assign o_byte_rs = rs_ff;
	assign o_byte_tgl = tgl_ff;

endmodule // lcdh_serial_rx

// [rtl/lcdh_host_if.sv]
// Contract
// - Strap a low: serial port, write only
// - Serial bits taken only while select low
// - Serial bytes travel most significant bit first
// - Sample on rising clock, byte at eighth
// - Display data write advances column by one
// - Bytes stream back to back while selected
// - Select rising mid-byte drops partial byte
// - Strap b low: three-line, select input unused
// - Three-line: counted burst is data, then command
// - Select rising mid-burst ends burst, next command
// - Four-line: select high data, low command
// - Both straps high: 68-style parallel port
// - 68-style access only select low, strobe high
// - Parallel: select high data, low command
// - Strap a high, b low: 80-style port
// - First display read after address is dummy
`include "lcdh_defines.svh"

module lcdh_host_if #(
	parameter int BYTE_W = `LCDH_BYTE_BITS,
	parameter int COL_W = `LCDH_COL_W
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Link clock of the serial port
	input wire logic i_sclk,
	// Pins
	input wire logic i_port_type_strap_a,
	input wire logic i_port_type_strap_b,
	input wire logic i_cs_n,
	input wire logic i_data_cmd_select,
	input wire logic i_serial_in_line,
	input wire logic i_rw,
	input wire logic i_e,
	input wire logic i_wr_n,
	input wire logic i_rd_n,
	input wire logic [BYTE_W-1:0] i_db,
	output logic [BYTE_W-1:0] o_db,
	output logic o_db_oe,
	// Core side
	input wire logic [BYTE_W-1:0] i_status,
	input wire logic [BYTE_W-1:0] i_ram_rdata,
	input wire logic i_col_load,
	input wire logic [COL_W-1:0] i_col_value,
	input wire logic i_len_load,
	input wire logic [`LCDH_LEN_W-1:0] i_len_value,
	output logic o_wr_valid,
	output logic [BYTE_W-1:0] o_wr_data,
	output logic o_wr_is_data,
	output logic o_rd_strobe,
	output logic [COL_W-1:0] o_col_addr,
	output logic [1:0] o_mode
);

	// Link-domain byte and its event toggle
	logic [BYTE_W-1:0] ser_byte;
	logic ser_rs;
	logic ser_tgl;

	// Two-stage synchronisers; stage one is read only by stage two
	logic [1:0] strap_s1_ff, strap_s2_ff;
	logic cs_s1_ff, cs_s2_ff, cs_s3_ff;
	logic rs_s1_ff, rs_s2_ff;
	logic rw_s1_ff, rw_s2_ff;
	logic e_s1_ff, e_s2_ff;
	logic wr_s1_ff, wr_s2_ff;
	logic rd_s1_ff, rd_s2_ff;
	logic [BYTE_W-1:0] db_s1_ff, db_s2_ff;
	logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;

	// Mode, captured one edge after reset release
	logic [1:0] mode_ff;
	logic mode_ok_ff;
	// Parallel access state
	lcdh_pkg::lcdh_acc_e acc_ff, nxt_acc;
	logic acc_rs_ff;
	// Remaining bytes of a counted burst
	logic [`LCDH_BURST_W-1:0] burst_ff;
	// Next display read returns the fixed reset byte, not the latch
	logic dummy_ff;
	// Prefetched display data for reads
	logic [BYTE_W-1:0] rd_latch_ff;
	logic [COL_W-1:0] col_ff;
	logic [BYTE_W-1:0] wr_data_ff;
	// Last bus value sampled inside a write strobe
	logic [BYTE_W-1:0] wr_hold_ff;
	logic wr_valid_ff;
	logic wr_is_data_ff;
	logic rd_strobe_ff;
	logic [BYTE_W-1:0] db_out_ff;
	logic db_oe_ff;

	// Decoded events
	logic ser_mode;
	logic par_active;
	logic par_read;
	logic ser_event;
	logic cs_rise;
	logic ser_is_data;
	logic par_wr_done;
	logic par_rd_start;
	logic disp_write;
	logic disp_read;

	// Is the mode a serial one
	function automatic logic is_serial(input logic [1:0] mode);
		return mode == lcdh_pkg::LCDH_SER3 || mode == lcdh_pkg::LCDH_SER4;
	endfunction

	// Serial receiver on the link clock
	lcdh_serial_rx u_serial_rx (
		.i_sclk(i_sclk),
		.i_reset(i_reset),
		.i_cs_n(i_cs_n),
		.i_serial_in_line(i_serial_in_line),
		.i_data_cmd_select(i_data_cmd_select),
		.o_byte(ser_byte),
		.o_byte_rs(ser_rs),
		.o_byte_tgl(ser_tgl)
	);

	// Pin synchronisers
	always_ff @(posedge i_clk_sys) begin
		strap_s1_ff <= {i_port_type_strap_a, i_port_type_strap_b};
		strap_s2_ff <= strap_s1_ff;
		cs_s1_ff <= i_cs_n;
		cs_s2_ff <= cs_s1_ff;
		cs_s3_ff <= cs_s2_ff;
		rs_s1_ff <= i_data_cmd_select;
		rs_s2_ff <= rs_s1_ff;
		rw_s1_ff <= i_rw;
		rw_s2_ff <= rw_s1_ff;
		e_s1_ff <= i_e;
		e_s2_ff <= e_s1_ff;
		wr_s1_ff <= i_wr_n;
		wr_s2_ff <= wr_s1_ff;
		rd_s1_ff <= i_rd_n;
		rd_s2_ff <= rd_s1_ff;
		db_s1_ff <= i_db;
		db_s2_ff <= db_s1_ff;
	end

	// Byte toggle crossing; the third stage gives the edge
	always_ff @(posedge i_clk_sys) begin
		tgl_s1_ff <= ser_tgl;
		tgl_s2_ff <= tgl_s1_ff;
		tgl_s3_ff <= tgl_s2_ff;
	end

	// Straps are caught by a clocked process after reset, not by the reset
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			mode_ff <= 2'h0;
			mode_ok_ff <= 1'b0;
		end else if (!mode_ok_ff) begin
			mode_ff <= strap_s2_ff;
			mode_ok_ff <= 1'b1;
		end
	end

	assign ser_mode = mode_ok_ff && is_serial(mode_ff);

	// Serial byte events; no read path exists in serial mode
	assign ser_event = ser_mode && (tgl_s2_ff ^ tgl_s3_ff);
	assign cs_rise = cs_s2_ff && !cs_s3_ff;

	// Data or command classification of a serial byte
	always_comb begin
		if (mode_ff == lcdh_pkg::LCDH_SER4) begin
			ser_is_data = ser_rs;
		end else begin
			ser_is_data = burst_ff != `LCDH_BURST_RST;
		end
	end

	// Parallel strobe decode per mode
	always_comb begin
		par_active = 1'b0;
		par_read = 1'b0;
		case (mode_ff)
			lcdh_pkg::LCDH_P68: begin
				par_active = !cs_s2_ff && e_s2_ff;
				par_read = rw_s2_ff;
			end
			lcdh_pkg::LCDH_P80: begin
				// Both strobes low is illegal; it is ignored, not guessed at
				par_active = !cs_s2_ff && (wr_s2_ff != rd_s2_ff);
				par_read = !rd_s2_ff;
			end
			default: begin
				par_active = 1'b0;
				par_read = 1'b0;
			end
		endcase
		if (!mode_ok_ff) begin
			par_active = 1'b0;
		end
	end

	// Parallel access tracker
	always_comb begin
		nxt_acc = acc_ff;
		case (acc_ff)
			lcdh_pkg::LCDH_IDLE: begin
				if (par_active) begin
					nxt_acc = par_read ? lcdh_pkg::LCDH_READ : lcdh_pkg::LCDH_WRITE;
				end
			end
			lcdh_pkg::LCDH_WRITE, lcdh_pkg::LCDH_READ: begin
				if (!par_active) begin
					nxt_acc = lcdh_pkg::LCDH_IDLE;
				end
			end
			default: begin
				nxt_acc = lcdh_pkg::LCDH_IDLE;
			end
		endcase
	end

	// Access state register and the select level it was started with
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			acc_ff <= lcdh_pkg::LCDH_IDLE;
			acc_rs_ff <= 1'b0;
		end else begin
			acc_ff <= nxt_acc;
			if (acc_ff == lcdh_pkg::LCDH_IDLE && par_active) begin
				acc_rs_ff <= rs_s2_ff;
			end
		end
	end

	// Bus sampled on every cycle of an active write strobe; the host may
	// move the bus as soon as the strobe ends, so the end is too late
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			wr_hold_ff <= `LCDH_BYTE_RST;
		end else if (par_active && !par_read) begin
			wr_hold_ff <= db_s2_ff;
		end
	end

	// Write completes as the strobe ends, with the in-strobe sample
	assign par_wr_done = acc_ff == lcdh_pkg::LCDH_WRITE && !par_active;
	assign par_rd_start = acc_ff == lcdh_pkg::LCDH_IDLE && par_active && par_read;

	assign disp_write = (ser_event && ser_is_data) || (par_wr_done && acc_rs_ff);
	assign disp_read = par_rd_start && rs_s2_ff;

	// Written byte toward the command decoder and display memory
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			wr_valid_ff <= 1'b0;
			wr_data_ff <= `LCDH_BYTE_RST;
			wr_is_data_ff <= 1'b0;
		end else begin
			wr_valid_ff <= ser_event || par_wr_done;
			if (ser_event) begin
				wr_data_ff <= ser_byte;
				wr_is_data_ff <= ser_is_data;
			end else if (par_wr_done) begin
				wr_data_ff <= wr_hold_ff;
				wr_is_data_ff <= acc_rs_ff;
			end
		end
	end

	// Burst count; a byte in the same cycle as select rising is still kept
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			burst_ff <= `LCDH_BURST_RST;
		end else if (mode_ff != lcdh_pkg::LCDH_SER3) begin
			burst_ff <= `LCDH_BURST_RST;
		end else if (cs_rise) begin
			burst_ff <= `LCDH_BURST_RST;
		end else if (i_len_load) begin
			burst_ff <= {1'b0, i_len_value} + 9'h001;
		end else if (ser_event && ser_is_data) begin
			burst_ff <= burst_ff - 9'h001;
		end
	end

	// Column address: loaded by command, steps once per data byte
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			col_ff <= `LCDH_COL_RST;
		end else if (i_col_load) begin
			col_ff <= i_col_value;
		end else if (disp_write || disp_read) begin
			col_ff <= col_ff + 1'b1;
		end
	end

	// Dummy marker; the read pipeline runs one column ahead of the host
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			dummy_ff <= 1'b1;
		end else if (i_col_load) begin
			dummy_ff <= 1'b1;
		end else if (disp_read) begin
			dummy_ff <= 1'b0;
		end
	end

	// Prefetch latch, refilled from memory at each display read
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			rd_latch_ff <= `LCDH_BYTE_RST;
		end else if (disp_read) begin
			rd_latch_ff <= i_ram_rdata;
		end
	end

	// Read bus drive; status for select low, latched data for high
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			db_out_ff <= `LCDH_BYTE_RST;
			db_oe_ff <= 1'b0;
			rd_strobe_ff <= 1'b0;
		end else begin
			rd_strobe_ff <= disp_read;
			if (par_rd_start) begin
				// A dummy read gives a fixed byte rather than a stale column
				db_out_ff <= rs_s2_ff ? (dummy_ff ? `LCDH_BYTE_RST : rd_latch_ff) : i_status;
				db_oe_ff <= 1'b1;
			end else if (nxt_acc != lcdh_pkg::LCDH_READ) begin
				db_oe_ff <= 1'b0;
			end
		end
	end

	assign o_db = db_out_ff;
	assign o_db_oe = db_oe_ff;
	assign o_wr_valid = wr_valid_ff;
	assign o_wr_data = wr_data_ff;
	assign o_wr_is_data = wr_is_data_ff;
	assign o_rd_strobe = rd_strobe_ff;
	assign o_col_addr = col_ff;
	assign o_mode = mode_ff;

endmodule // lcdh_host_if

// [dv/lcdh_host_if_props.sv]
module lcdh_host_if_props #(
	parameter int BYTE_W = 8,
	parameter int COL_W = 7
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_port_type_strap_a,
	input wire logic i_port_type_strap_b,
	input wire logic i_data_cmd_select,
	input wire logic [BYTE_W-1:0] i_status,
	input wire logic i_col_load,
	input wire logic [COL_W-1:0] i_col_value,
	input wire logic [BYTE_W-1:0] o_db,
	input wire logic o_db_oe,
	input wire logic o_wr_valid,
	input wire logic o_wr_is_data,
	input wire logic o_rd_strobe,
	input wire logic [COL_W-1:0] o_col_addr,
	input wire logic [1:0] o_mode
);
	timeunit 1ns;
	timeprecision 1ps;

	// All checks live in the system clock domain
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	one_write_a: assert property (o_wr_valid |=> !o_wr_valid)
		else $error("write pulse longer than one cycle");
	one_read_a: assert property (o_rd_strobe |=> !o_rd_strobe)
		else $error("read pulse longer than one cycle");
	// Column moves only by one unless the core loads it
	col_step_a: assert property (!$past(i_col_load) && $changed(o_col_addr) |->
		o_col_addr == $past(o_col_addr) + 1'b1) else $error("column step not one");
	col_load_a: assert property (i_col_load |=> o_col_addr == $past(i_col_value))
		else $error("column load lost");
	serial_no_read_a: assert property (!o_mode[1] |-> !o_db_oe)
		else $error("bus driven in serial form");
	mode_strap_a: assert property (!$past(i_reset) |->
		o_mode == {i_port_type_strap_a, i_port_type_strap_b}) else $error("mode differs from straps");
	par_kind_a: assert property (o_wr_valid && o_mode[1] |-> o_wr_is_data == i_data_cmd_select)
		else $error("parallel write kind wrong");
	status_read_a: assert property ($rose(o_db_oe) && !i_data_cmd_select |-> o_db == i_status)
		else $error("status read wrong");
endmodule // lcdh_host_if_props

bind lcdh_host_if lcdh_host_if_props #(.BYTE_W(BYTE_W), .COL_W(COL_W)) u_props (.i_clk_sys, .i_reset,
	.i_port_type_strap_a, .i_port_type_strap_b, .i_data_cmd_select, .i_status, .i_col_load, .i_col_value,
	.o_db, .o_db_oe, .o_wr_valid, .o_wr_is_data, .o_rd_strobe, .o_col_addr, .o_mode);

// [dv/lcdh_ser_host.sv]
module lcdh_ser_host (
	output logic o_sclk,
	output logic o_serial_in_line
);
	timeunit 1ns;
	timeprecision 1ps;

	// Clock stands low outside frames
	initial begin
		o_sclk = 1'b0;
		o_serial_in_line = 1'b0;
	end

	// Top n bits of a byte at 32 ns per bit; data moves while the clock is low
	task automatic send(input logic [7:0] b, input int n);
		#7;
		for (int i = 7; i > 7 - n; i--) begin
			o_serial_in_line = b[i];
			#16 o_sclk = 1'b1;
			#16 o_sclk = 1'b0;
		end
		// Line no longer holds the last bit
		o_serial_in_line = ~o_serial_in_line;
	endtask
endmodule // lcdh_ser_host

// [dv/tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// Pins and core side stimulus
	// Reset and select start low so that their first raise, non-blocking at time zero, is a real edge
	logic clk = 1'b0, rst = 1'b0, sa = 1'b0, sb = 1'b0, cs_n = 1'b0, rs = 1'b0, rw = 1'b0, e = 1'b0;
	logic wr_n = 1'b1, rd_n = 1'b1, cl = 1'b0, ll = 1'b0;
	logic [7:0] db = 8'h00, lv = 8'h00;
	logic [6:0] cv = 7'h00;
	wire sclk, sd, oe, wv, isd, rds;
	wire [7:0] odb, wd;
	wire [6:0] col;
	wire [1:0] md;
	// Written bytes as {is_data, data}
	logic [8:0] q[$];
	int n_mismatch = 0, total_checks = 0, cyc = 0, n_rd = 0;

	initial forever #10 clk = ~clk;

	lcdh_ser_host host (.o_sclk(sclk), .o_serial_in_line(sd));
	lcdh_host_if DUT (.i_clk_sys(clk), .i_reset(rst), .i_sclk(sclk), .i_port_type_strap_a(sa),
		.i_port_type_strap_b(sb), .i_cs_n(cs_n), .i_data_cmd_select(rs), .i_serial_in_line(sd), .i_rw(rw),
		.i_e(e), .i_wr_n(wr_n), .i_rd_n(rd_n), .i_db(db), .o_db(odb), .o_db_oe(oe), .i_status(8'h96),
		.i_ram_rdata({1'b0, col} ^ 8'h5A), .i_col_load(cl), .i_col_value(cv), .i_len_load(ll),
		.i_len_value(lv), .o_wr_valid(wv), .o_wr_data(wd), .o_wr_is_data(isd), .o_rd_strobe(rds),
		.o_col_addr(col), .o_mode(md));

	// Monitor on the falling edge, where outputs have settled
	always @(negedge clk) begin
		cyc++;
		if (wv) q.push_back({isd, wd});
		if (rds) n_rd++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		total_checks++;
		if (g !== x) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	// Next written byte; an empty queue never matches
	task automatic qc(input logic [8:0] x);
		logic [8:0] g;
		g = 'x;
		if (q.size() > 0) g = q.pop_front();
		chk(16'(g), 16'(x));
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Serial byte, then back onto a falling edge before any pin moves
	task automatic snd(input logic [7:0] b, input int n);
		host.send(b, n);
		wait_n(1);
	endtask

	// Straps change only under reset, held five cycles
	task automatic set_mode(input logic a, input logic b);
		rst <= 1'b1;
		cs_n <= 1'b1;
		sa = a;
		sb = b;
		wait_n(5);
		rst = 1'b0;
		wait_n(4);
		chk(16'(md), 16'({a, b}));
	endtask

	task automatic pulse_col(input logic [6:0] v);
		cv = v;
		cl = 1'b1;
		wait_n(1);
		cl = 1'b0;
	endtask

	task automatic pulse_len(input logic [7:0] v);
		lv = v;
		ll = 1'b1;
		wait_n(1);
		ll = 1'b0;
	endtask

	// One parallel access; strobe held five cycles for the synchroniser
	task automatic pacc(input logic r, input logic d, input logic [7:0] v, output logic [8:0] got);
		rs = d;
		db = v;
		rw = r;
		cs_n = 1'b0;
		e = sb;
		wr_n = sb | r;
		rd_n = sb | !r;
		wait_n(5);
		got = {oe, odb};
		// Bus moves away with the strobe; a write must keep the in-strobe value
		db = ~v;
		cs_n = 1'b1;
		e = 1'b0;
		wr_n = 1'b1;
		rd_n = 1'b1;
		wait_n(6);
	endtask

	// Pins that must not start an access
	task automatic noacc(input logic c, input logic ee, input logic w, input logic r);
		cs_n = c;
		e = ee;
		wr_n = w;
		rd_n = r;
		rw = 1'b0;
		db = 8'hAA;
		wait_n(6);
		chk({oe, 15'(q.size())}, 16'h0000);
		cs_n = 1'b1;
		e = 1'b0;
		wr_n = 1'b1;
		rd_n = 1'b1;
		wait_n(6);
		chk(16'(q.size()), 16'h0000);
	endtask

	task automatic t_ser4();
		set_mode(1'b0, 1'b1);
		noacc(1'b0, 1'b1, 1'b1, 1'b0);
		pulse_col(7'h10);
		cs_n = 1'b0;
		rs = 1'b0;
		snd(8'hA5, 8);
		rs = 1'b1;
		snd(8'h3C, 8);
		snd(8'h81, 5);
		cs_n = 1'b1;
		snd(8'h7E, 8);
		wait_n(10);
		qc({1'b0, 8'hA5});
		qc({1'b1, 8'h3C});
		chk(16'(q.size()), 16'h0000);
		chk(16'(col), 16'h0011);
	endtask

	task automatic t_ser3();
		logic [7:0] lens[2] = '{8'h00, 8'hFF};
		set_mode(1'b0, 1'b0);
		rs = 1'b1;
		foreach (lens[k]) begin
			pulse_len(lens[k]);
			cs_n = 1'b0;
			for (int i = 0; i <= lens[k]; i++) snd(i[7:0], 8);
			snd(8'hC6, 8);
			cs_n = 1'b1;
			wait_n(8);
			for (int i = 0; i <= lens[k]; i++) qc({1'b1, i[7:0]});
			qc({1'b0, 8'hC6});
		end
		pulse_len(8'h03);
		cs_n = 1'b0;
		snd(8'h55, 8);
		snd(8'hE7, 3);
		cs_n = 1'b1;
		wait_n(8);
		cs_n = 1'b0;
		snd(8'h44, 8);
		cs_n = 1'b1;
		wait_n(8);
		qc({1'b1, 8'h55});
		qc({1'b0, 8'h44});
		chk(16'(q.size()), 16'h0000);
	endtask

	task automatic t_p68();
		logic [8:0] r;
		set_mode(1'b1, 1'b1);
		pacc(1'b0, 1'b0, 8'h5A, r);
		pacc(1'b0, 1'b1, 8'hC3, r);
		pacc(1'b1, 1'b0, 8'h00, r);
		chk(16'(r), 16'h0196);
		pacc(1'b1, 1'b1, 8'h00, r);
		chk(16'(n_rd), 16'h0001);
		qc({1'b0, 8'h5A});
		qc({1'b1, 8'hC3});
		noacc(1'b0, 1'b0, 1'b0, 1'b0);
		noacc(1'b1, 1'b1, 1'b1, 1'b1);
	endtask

	task automatic t_p80();
		logic [8:0] r;
		set_mode(1'b1, 1'b0);
		pacc(1'b0, 1'b1, 8'h3E, r);
		qc({1'b1, 8'h3E});
		pacc(1'b1, 1'b0, 8'h00, r);
		chk(16'(r), 16'h0196);
		pulse_col(7'h20);
		pacc(1'b1, 1'b1, 8'h00, r);
		pacc(1'b1, 1'b1, 8'h00, r);
		chk(16'(r), 16'h017A);
		chk(16'(col), 16'h0022);
		chk(16'(n_rd), 16'h0003);
		noacc(1'b0, 1'b1, 1'b0, 1'b0);
		noacc(1'b1, 1'b0, 1'b0, 1'b1);
	endtask

	initial begin
		t_ser4();
		t_ser3();
		t_p68();
		t_p80();
		stop_test();
	end
endmodule // tb
